// file: src/mntc_pkg.sv
/*
  Package for the network control / status / transmit control register block:
  register offsets, bit positions, reset values and timing constants.
  Assumes a 100 MHz system clock.
*/
package mntc_pkg;

  // ****************************************************************
  // register offsets (byte-wide registers on the vendor command port)
  // ****************************************************************
  localparam logic [7:0] NET_CONTROL_ADDR  = 8'h00;
  localparam logic [7:0] NET_STATUS_ADDR   = 8'h01;
  localparam logic [7:0] TX_CONTROL_ADDR   = 8'h02;
  localparam logic [7:0] OVF_COUNTER_ADDR  = 8'h07;

  // ****************************************************************
  // network control bits
  // ****************************************************************
  localparam int NC_OUTSIDE_PHY = 7;
  localparam int NC_WAKE_EN     = 6;
  localparam int NC_W1C_MODE    = 5;
  localparam int NC_FORCE_COL   = 4;
  localparam int NC_FULL_DUPLEX = 3;
  localparam int NC_LOOPBACK_HI = 2;
  localparam int NC_LOOPBACK_LO = 1;
  localparam int NC_SOFT_RESET  = 0;

  // ****************************************************************
  // network status bits
  // ****************************************************************
  localparam int NS_SPEED_10  = 7;
  localparam int NS_LINK_UP   = 6;
  localparam int NS_WAKE      = 5;
  localparam int NS_SPARE_HI  = 3;
  localparam int NS_SPARE_LO  = 2;
  localparam int NS_RX_OVF    = 1;
  localparam int NS_RX_READY  = 0;

  // ****************************************************************
  // transmit control bits
  // ****************************************************************
  localparam int TC_JABBER_OFF = 6;
  localparam int TC_EXCESS_COL = 5;
  localparam int TC_PAD_OFF    = 2;
  localparam int TC_FCS_OFF    = 1;
  localparam logic [7:0] TC_WRITE_MASK = 8'h7f;

  // ****************************************************************
  // force-mode input bits
  // ****************************************************************
  localparam int FM_FORCE_EN     = 5;
  localparam int FM_FORCE_SPEED  = 2;
  localparam int FM_FORCE_DUPLEX = 1;
  localparam int FM_FORCE_LINK   = 0;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [1:0] LOOPBACK_NORMAL = 2'h0;

  // ****************************************************************
  // thresholds and timing
  // ****************************************************************
  localparam int RX_OVF_SET_BYTES   = 544;
  localparam int RX_OVF_CLEAR_BYTES = 2048;
  localparam int TX_JABBER_BYTES    = 2048;
  localparam int TX_MAX_COLLISIONS  = 15;
  localparam int TX_MIN_FRAME_BYTES = 64;
  localparam int CLK_PERIOD_NS      = 10;
  localparam int SWRST_TIME_NS      = 10000;
  localparam int SWRST_CYCLES       = SWRST_TIME_NS / CLK_PERIOD_NS;
  localparam int SWRST_CNT_W        = 11;

endpackage : mntc_pkg

// file: src/mntc_tx_policy.sv
/*
  Transmit frame policy: jabber cut, excess-collision abort, padding and
  frame check sequence decisions for the frame now in transmission.
  Assumes byte and collision counts come from the transmit engine.
*/
`timescale 1ns/1ps
module mntc_tx_policy
  import mntc_pkg::*;
#(
  parameter int LEN_W = 16,
  parameter int COL_W = 5
)
(
  input  wire logic [7:0]       tx_control,
  input  wire logic [LEN_W-1:0] tx_byte_count,
  input  wire logic [COL_W-1:0] tx_collision_count,
  output logic                  tx_jabber_cut,
  output logic                  tx_abort,
  output logic                  tx_pad_needed,
  output logic                  tx_fcs_append
);

  localparam logic [LEN_W-1:0] JABBER_LIMIT = LEN_W'(TX_JABBER_BYTES);
  localparam logic [LEN_W-1:0] MIN_FRAME    = LEN_W'(TX_MIN_FRAME_BYTES);
  localparam logic [COL_W-1:0] MAX_COL      = COL_W'(TX_MAX_COLLISIONS);

  wire   tx_jabber_off           = tx_control[TC_JABBER_OFF];
  wire   excess_collision_policy = tx_control[TC_EXCESS_COL];
  wire   tx_pad_off              = tx_control[TC_PAD_OFF];
  wire   tx_fcs_off              = tx_control[TC_FCS_OFF];

  // frame may not run past the cap while the jabber timer is on
  assign tx_jabber_cut = !tx_jabber_off && (tx_byte_count >= JABBER_LIMIT);
  assign tx_abort      = !excess_collision_policy && (tx_collision_count > MAX_COL);
  assign tx_pad_needed = !tx_pad_off && (tx_byte_count < MIN_FRAME);
  assign tx_fcs_append = !tx_fcs_off;

endmodule : mntc_tx_policy

// file: src/mntc_regs.sv
/*
  Network control, network status and transmit control registers of the
  USB-to-Ethernet MAC, with software reset timing and transmit policy.
  Assumes a vendor command engine drives the byte register port and that
  PHY status, wake events and receive FIFO levels are synchronous to clk.
*/
// Notes on behaviour
// - control bit 7 picks outside PHY, strap low
// - force-mode bit 5 overrides PHY selection
// - control bit 6 enables wake; clearing clears wake
// - write-one-clear mode governs listed status bits
// - control bit 4 forces collision in loopback
// - bit 3 duplex, writable only with outside PHY
// - force-mode bits 5,1 override duplex
// - loopback field bits 2:1 selects four modes
// - bit 0 soft reset, self-clears after 10us
// - status bit 7 speed, outside-writable, forceable
// - status bit 6 link, outside-writable, forceable
// - wake flag set on event, cleared by one
// - overflow flag below 544 free, clears above 2K
// - status bit 0 high while frame pending
// - jabber caps transmit at 2048 bytes unless off
// - abort after 15 collisions unless retry policy
// - pad short frames to 64 unless off
// - append check sequence unless off
// - registers via vendor commands; srst restores defaults, soft reset keeps control bits 7,6 and wake flag
// - mode zero: overflow counter clears on read
`timescale 1ns/1ps
module mntc_regs
  import mntc_pkg::*;
#(
  parameter int FREE_W = 16,
  parameter int LEN_W  = 16,
  parameter int COL_W  = 5
)
(
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              ce,
  // vendor register command port
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  output logic [7:0]             reg_rdata,
  output logic                   reg_rvalid,
  // straps, force mode and PHY state
  input  wire logic              test_strap_one,
  input  wire logic [7:0]        force_mode,
  input  wire logic              int_phy_full_duplex,
  input  wire logic              int_phy_speed_10,
  input  wire logic              int_phy_link_up,
  // wake and receive FIFO state
  input  wire logic              wake_event,
  input  wire logic [FREE_W-1:0] rx_fifo_free_bytes,
  input  wire logic              rx_frame_pending,
  // transmit engine state
  input  wire logic [LEN_W-1:0]  tx_byte_count,
  input  wire logic [COL_W-1:0]  tx_collision_count,
  // control outputs
  output logic                   outside_phy_active,
  output logic                   full_duplex_active,
  output logic                   speed_10_active,
  output logic                   link_up_active,
  output logic [1:0]             loopback_select,
  output logic                   forced_collision_test,
  output logic                   wake_function_enable,
  output logic                   write_one_clear_select,
  output logic                   soft_reset_active,
  output logic                   ovf_counter_clear,
  output logic                   tx_jabber_cut,
  output logic                   tx_abort,
  output logic                   tx_pad_needed,
  output logic                   tx_fcs_append
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // forced value wins, then the written value with the outside PHY,
  // otherwise the internal PHY reports
  function automatic logic phy_pick(input logic force_en, input logic force_val,
                                    input logic outside, input logic wr_val,
                                    input logic int_val);
    phy_pick = force_en ? force_val : (outside ? wr_val : int_val);
  endfunction : phy_pick

  localparam logic [SWRST_CNT_W-1:0] SWRST_LOAD = SWRST_CNT_W'(SWRST_CYCLES);
  localparam logic [SWRST_CNT_W-1:0] CNT_ONE    = SWRST_CNT_W'(1);
  localparam logic [FREE_W-1:0] OVF_SET_LVL   = FREE_W'(RX_OVF_SET_BYTES);
  localparam logic [FREE_W-1:0] OVF_CLEAR_LVL = FREE_W'(RX_OVF_CLEAR_BYTES);

  // ****************************************************************
  // state
  // ****************************************************************
  logic                   outside_phy_select;
  logic                   write_one_clear_sel;
  logic                   force_col;
  logic                   duplex_written;
  logic [1:0]             loopback_field;
  logic                   speed_written;
  logic                   link_written;
  logic                   wake_event_flag;
  logic                   wake_enable;
  logic [1:0]             status_spare;
  logic                   receive_overflow_flag;
  logic                   rx_ready_flag;
  logic [7:0]             transmit_control;
  logic [SWRST_CNT_W-1:0] swrst_count;

  // ****************************************************************
  // decode
  // ****************************************************************
  wire   wr_ncr   = ce && reg_wr && (reg_addr == NET_CONTROL_ADDR);
  wire   wr_nsr   = ce && reg_wr && (reg_addr == NET_STATUS_ADDR);
  wire   wr_tcr   = ce && reg_wr && (reg_addr == TX_CONTROL_ADDR);
  wire   wr_ovf   = ce && reg_wr && (reg_addr == OVF_COUNTER_ADDR);
  wire   rd_ovf   = ce && reg_rd && (reg_addr == OVF_COUNTER_ADDR);
  wire   swrst_on = (swrst_count != '0);

  wire   swrst_start = wr_ncr && reg_wdata[NC_SOFT_RESET];
  wire   swrst_stop  = wr_ncr && !reg_wdata[NC_SOFT_RESET];
  wire   swrst_apply = swrst_start || swrst_on;

  wire   force_en     = force_mode[FM_FORCE_EN];
  // strap high disables the outside PHY unless forced
  wire   phy_outside  = force_en || (outside_phy_select && !test_strap_one);

  wire   duplex_eff = phy_pick(force_en, force_mode[FM_FORCE_DUPLEX], phy_outside,
                               duplex_written, int_phy_full_duplex);
  wire   speed_eff  = phy_pick(force_en, force_mode[FM_FORCE_SPEED], phy_outside,
                               speed_written, int_phy_speed_10);
  wire   link_eff   = phy_pick(force_en, force_mode[FM_FORCE_LINK], phy_outside,
                               link_written, int_phy_link_up);

  // wake enable after this cycle's write
  wire   next_wake_enable = wr_ncr ? reg_wdata[NC_WAKE_EN] : wake_enable;
  wire   wake_set         = wake_event && next_wake_enable;
  wire   wake_clr         = (wr_nsr && reg_wdata[NS_WAKE]) || !next_wake_enable;
  // event wins over a write-one clear, but a disabled function holds none
  wire   next_wake_flag   = wake_set || (wake_event_flag && !wake_clr);

  wire [1:0] spare_clr = (wr_nsr && write_one_clear_sel) ?
                         reg_wdata[NS_SPARE_HI:NS_SPARE_LO] : 2'h0;

  wire   next_rx_ovf = (rx_fifo_free_bytes < OVF_SET_LVL) ? 1'b1 :
                       (rx_fifo_free_bytes > OVF_CLEAR_LVL) ? 1'b0 :
                       receive_overflow_flag;

  // counter itself lives elsewhere; this is its clear strobe
  wire   next_ovf_clear = wr_ovf || (rd_ovf && !write_one_clear_sel);

  wire [7:0] ncr_view = {outside_phy_select, wake_enable, write_one_clear_sel, force_col,
                         duplex_eff, loopback_field, swrst_on};
  wire [7:0] nsr_view = {speed_eff, link_eff, wake_event_flag, 1'b0, status_spare,
                         receive_overflow_flag, rx_ready_flag};
  wire [7:0] next_rdata = (reg_addr == NET_CONTROL_ADDR) ? ncr_view :
                          (reg_addr == NET_STATUS_ADDR)  ? nsr_view :
                          (reg_addr == TX_CONTROL_ADDR)  ? transmit_control :
                          ZERO_BYTE;

  wire   pol_jabber;
  wire   pol_abort;
  wire   pol_pad;
  wire   pol_fcs;

  mntc_tx_policy #(
    .LEN_W (LEN_W),
    .COL_W (COL_W)
  ) u_tx_policy (
    .tx_control         (transmit_control),
    .tx_byte_count      (tx_byte_count),
    .tx_collision_count (tx_collision_count),
    .tx_jabber_cut      (pol_jabber),
    .tx_abort           (pol_abort),
    .tx_pad_needed      (pol_pad),
    .tx_fcs_append      (pol_fcs)
  );

  // ****************************************************************
  // software reset timer
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (srst)
      swrst_count <= '0;
    else if (ce)
    begin
      if (swrst_start)
        swrst_count <= SWRST_LOAD;
      else if (swrst_stop)
        swrst_count <= '0;
      else if (swrst_on)
        swrst_count <= swrst_count - CNT_ONE;
    end
  end

  // ****************************************************************
  // power-on-only bits: kept through software reset
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      outside_phy_select <= 1'b0;
      wake_enable        <= 1'b0;
      wake_event_flag    <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_ncr)
        outside_phy_select <= reg_wdata[NC_OUTSIDE_PHY];
      wake_enable     <= next_wake_enable;
      wake_event_flag <= next_wake_flag;
    end
  end

  // ****************************************************************
  // software-resettable control and status bits
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (srst || (ce && swrst_apply))
    begin
      write_one_clear_sel <= 1'b0;
      force_col           <= 1'b0;
      duplex_written      <= 1'b0;
      loopback_field      <= LOOPBACK_NORMAL;
      speed_written       <= 1'b0;
      link_written        <= 1'b0;
      status_spare        <= 2'h0;
      transmit_control    <= ZERO_BYTE;
    end
    else if (ce)
    begin
      if (wr_ncr)
      begin
        write_one_clear_sel <= reg_wdata[NC_W1C_MODE];
        force_col           <= reg_wdata[NC_FORCE_COL];
        loopback_field      <= reg_wdata[NC_LOOPBACK_HI:NC_LOOPBACK_LO];
        if (phy_outside)
          duplex_written <= reg_wdata[NC_FULL_DUPLEX];
      end
      if (wr_nsr && phy_outside)
      begin
        speed_written <= reg_wdata[NS_SPEED_10];
        link_written  <= reg_wdata[NS_LINK_UP];
      end
      status_spare <= status_spare & ~spare_clr;
      if (wr_tcr)
        transmit_control <= reg_wdata & TC_WRITE_MASK;
    end
  end

  // ****************************************************************
  // receive FIFO status
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      receive_overflow_flag <= 1'b0;
      rx_ready_flag         <= 1'b0;
    end
    else if (ce)
    begin
      receive_overflow_flag <= next_rx_ovf;
      rx_ready_flag         <= rx_frame_pending;
    end
  end

  // ****************************************************************
  // read port and strobes
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      reg_rdata         <= ZERO_BYTE;
      reg_rvalid        <= 1'b0;
      ovf_counter_clear <= 1'b0;
    end
    else if (ce)
    begin
      reg_rvalid        <= reg_rd;
      ovf_counter_clear <= next_ovf_clear;
      if (reg_rd)
        reg_rdata <= next_rdata;
    end
  end

  // ****************************************************************
  // registered control outputs
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      outside_phy_active     <= 1'b0;
      full_duplex_active     <= 1'b0;
      speed_10_active        <= 1'b0;
      link_up_active         <= 1'b0;
      loopback_select        <= LOOPBACK_NORMAL;
      forced_collision_test  <= 1'b0;
      wake_function_enable   <= 1'b0;
      write_one_clear_select <= 1'b0;
      soft_reset_active      <= 1'b0;
      tx_jabber_cut          <= 1'b0;
      tx_abort               <= 1'b0;
      tx_pad_needed          <= 1'b0;
      tx_fcs_append          <= 1'b0;
    end
    else if (ce)
    begin
      outside_phy_active     <= phy_outside;
      full_duplex_active     <= duplex_eff;
      speed_10_active        <= speed_eff;
      link_up_active         <= link_eff;
      loopback_select        <= loopback_field;
      // only meaningful while looped back
      forced_collision_test  <= force_col && (loopback_field != LOOPBACK_NORMAL);
      wake_function_enable   <= wake_enable;
      write_one_clear_select <= write_one_clear_sel;
      soft_reset_active      <= swrst_on;
      tx_jabber_cut          <= pol_jabber;
      tx_abort               <= pol_abort;
      tx_pad_needed          <= pol_pad;
      tx_fcs_append          <= pol_fcs;
    end
  end

endmodule : mntc_regs

// file: sim/mntc_chk.sv
/* Port-level checker for the network control register block.
   Assumes ce stays high while the bench runs and a 100 MHz clk. */
`timescale 1ns/1ps
module mntc_chk
  import mntc_pkg::*;
#(
  parameter int LEN_W = 16,
  parameter int COL_W = 5
)
(
  input wire logic             clk,
  input wire logic             srst,
  input wire logic             ce,
  input wire logic             reg_wr,
  input wire logic             reg_rd,
  input wire logic [7:0]       reg_addr,
  input wire logic [7:0]       reg_wdata,
  input wire logic             reg_rvalid,
  input wire logic             test_strap_one,
  input wire logic [7:0]       force_mode,
  input wire logic [LEN_W-1:0] tx_byte_count,
  input wire logic [COL_W-1:0] tx_collision_count,
  input wire logic             outside_phy_active,
  input wire logic             full_duplex_active,
  input wire logic             soft_reset_active,
  input wire logic             ovf_counter_clear,
  input wire logic             tx_jabber_cut,
  input wire logic             tx_abort,
  input wire logic             tx_pad_needed
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_swrst_wr;
    ce && reg_wr && reg_addr == NET_CONTROL_ADDR && reg_wdata[NC_SOFT_RESET];
  endsequence
  // timer is 1000 edges and the active flag lags by one; too long for a delay, so counted
  localparam logic [SWRST_CNT_W-1:0] SWRST_END_AGE = SWRST_CNT_W'(SWRST_CYCLES + 2);
  logic [SWRST_CNT_W-1:0] swrst_age;
  always_ff @(posedge clk)
  begin
    if (srst)
      swrst_age <= '0;
    else if (ce && reg_wr && reg_addr == NET_CONTROL_ADDR && reg_wdata[NC_SOFT_RESET])
      swrst_age <= SWRST_CNT_W'(1);
    else if (swrst_age == SWRST_END_AGE)
      swrst_age <= '0;
    else if (ce && swrst_age != '0)
      swrst_age <= swrst_age + SWRST_CNT_W'(1);
  end
  sequence s_swrst_end;
    swrst_age == SWRST_END_AGE;
  endsequence
  AST_SWRST_RUN: assert property (s_swrst_wr |-> ##[1:2] soft_reset_active)
    else $error("soft reset not started");
  AST_SWRST_END: assert property (s_swrst_end |-> !soft_reset_active)
    else $error("soft reset did not self clear");
  AST_RVALID: assert property (ce && reg_rd |=> reg_rvalid)
    else $error("read not answered");
  AST_OVF_CLR: assert property (ovf_counter_clear |-> $past(reg_addr) == OVF_COUNTER_ADDR)
    else $error("stray counter clear");
  AST_WR_CLR: assert property (ce && reg_wr && reg_addr == OVF_COUNTER_ADDR |=> ovf_counter_clear)
    else $error("counter clear missing");
  AST_STRAP: assert property (ce && test_strap_one && !force_mode[FM_FORCE_EN] |=> !outside_phy_active)
    else $error("strap did not block outside phy");
  AST_FORCE_PHY: assert property (ce && force_mode[FM_FORCE_EN] |=> outside_phy_active)
    else $error("force did not select outside phy");
  AST_FORCE_FDX: assert property (ce && force_mode[FM_FORCE_EN] |=>
    full_duplex_active == $past(force_mode[FM_FORCE_DUPLEX])) else $error("forced duplex lost");
  AST_JABBER: assert property (ce && tx_byte_count < TX_JABBER_BYTES |=> !tx_jabber_cut)
    else $error("early jabber cut");
  AST_ABORT: assert property (ce && tx_collision_count <= TX_MAX_COLLISIONS |=> !tx_abort)
    else $error("early collision abort");
  AST_PAD: assert property (ce && tx_byte_count >= TX_MIN_FRAME_BYTES |=> !tx_pad_needed)
    else $error("pad on long frame");
endmodule : mntc_chk
bind mntc_regs mntc_chk #(.LEN_W(LEN_W), .COL_W(COL_W)) u_chk (
  .clk, .srst, .ce, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rvalid, .test_strap_one,
  .force_mode, .tx_byte_count, .tx_collision_count, .outside_phy_active, .full_duplex_active,
  .soft_reset_active, .ovf_counter_clear, .tx_jabber_cut, .tx_abort, .tx_pad_needed);

// file: sim/mntc_phy_model.sv
/* Behavioural internal PHY status source.
   Assumes the bench asks for link and duplex as plain levels. */
`timescale 1ns/1ps
module mntc_phy_model
#(
  parameter int LINK_DELAY = 4
)
(
  input wire logic clk,
  input wire logic link_req,
  input wire logic duplex_req,
  output logic     int_phy_link_up,
  output logic     int_phy_full_duplex,
  output logic     int_phy_speed_10
);
  int cnt = 0;
  initial int_phy_speed_10 = 1'b0;
  initial int_phy_full_duplex = 1'b0;
  // link needs training time; speed and duplex mean nothing while down
  always @(posedge clk)
  begin
    cnt <= link_req ? ((cnt < LINK_DELAY) ? cnt + 1 : cnt) : 0;
    int_phy_link_up <= link_req && cnt >= LINK_DELAY;
    int_phy_speed_10 <= int_phy_link_up ? 1'b0 : ~int_phy_speed_10;
    int_phy_full_duplex <= int_phy_link_up ? duplex_req : ~int_phy_full_duplex;
  end
endmodule : mntc_phy_model

// file: sim/tb_top.sv
/* Self-checking bench for the network control register block.
   Assumes a 100 MHz clock and inputs driven 1 ns after each edge. */
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; $display("ERROR %0t: got %h exp %h", $time, a, b); end end
module tb_top;
  import mntc_pkg::*;
  logic clk, srst, ce, reg_wr, reg_rd, test_strap_one, wake_event, rx_frame_pending, link_req, duplex_req;
  logic [7:0] reg_addr, reg_wdata, force_mode, reg_rdata;
  logic [15:0] rx_fifo_free_bytes, tx_byte_count;
  logic [4:0] tx_collision_count;
  logic [1:0] loopback_select;
  logic reg_rvalid, int_phy_full_duplex, int_phy_speed_10, int_phy_link_up, outside_phy_active;
  logic full_duplex_active, speed_10_active, link_up_active, forced_collision_test, soft_reset_active;
  logic tx_jabber_cut, tx_abort, tx_pad_needed, tx_fcs_append;
  logic wake_function_enable, write_one_clear_select, ovf_counter_clear;
  int n_fail = 0;
  int n_compared = 0;
  mntc_regs uut (.clk, .srst, .ce, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
    .test_strap_one, .force_mode, .int_phy_full_duplex, .int_phy_speed_10, .int_phy_link_up, .wake_event,
    .rx_fifo_free_bytes, .rx_frame_pending, .tx_byte_count, .tx_collision_count, .outside_phy_active,
    .full_duplex_active, .speed_10_active, .link_up_active, .loopback_select, .forced_collision_test,
    .wake_function_enable, .write_one_clear_select, .soft_reset_active, .ovf_counter_clear,
    .tx_jabber_cut, .tx_abort, .tx_pad_needed, .tx_fcs_append);
  mntc_phy_model phy (.clk, .link_req, .duplex_req, .int_phy_link_up, .int_phy_full_duplex, .int_phy_speed_10);
  // ****************************************************************
  // bus tasks
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick(1);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    tick(1);
    reg_rd = 1'b1;
    reg_addr = a;
    tick(1);
    reg_rd = 1'b0;
    `CHK({reg_rvalid, reg_rdata}, {1'b1, exp})
  endtask : rc
  task automatic wake_pulse();
    wake_event = 1'b1;
    tick(1);
    wake_event = 1'b0;
  endtask : wake_pulse
  task automatic end_of_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    rc(NET_CONTROL_ADDR, 8'h00);
    rc(NET_STATUS_ADDR, 8'h40);
    rc(TX_CONTROL_ADDR, 8'h00);
    rc(8'h03, 8'h00);
    `CHK(tx_fcs_append, 1'b1)
    $display("test reset done");
  endtask : t_reset
  task automatic t_tx();
    logic [7:0] ctl[5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h66};
    logic [15:0] len[5] = '{16'h0800, 16'h07ff, 16'h003f, 16'h0040, 16'h0800};
    logic [4:0] col[5] = '{5'h10, 5'h0f, 5'h00, 5'h00, 5'h10};
    logic [3:0] exp[5] = '{4'hd, 4'h1, 4'h3, 4'h1, 4'h0};
    wr(TX_CONTROL_ADDR, 8'hff);
    rc(TX_CONTROL_ADDR, TC_WRITE_MASK);
    for (int i = 0; i < 5; i++)
    begin
      wr(TX_CONTROL_ADDR, ctl[i]);
      tx_byte_count = len[i];
      tx_collision_count = col[i];
      tick(2);
      `CHK({tx_jabber_cut, tx_abort, tx_pad_needed, tx_fcs_append}, exp[i])
    end
    $display("test tx policy done");
  endtask : t_tx
  task automatic t_phy();
    duplex_req = 1'b1;
    tick(3);
    rc(NET_CONTROL_ADDR, 8'h08);
    duplex_req = 1'b0;
    wr(NET_CONTROL_ADDR, 8'h08);
    rc(NET_CONTROL_ADDR, 8'h00);
    wr(NET_CONTROL_ADDR, 8'h80);
    wr(NET_CONTROL_ADDR, 8'h88);
    wr(NET_STATUS_ADDR, 8'h80);
    rc(NET_STATUS_ADDR, 8'h80);
    `CHK({outside_phy_active, full_duplex_active, speed_10_active, link_up_active}, 4'he)
    test_strap_one = 1'b1;
    tick(2);
    `CHK({outside_phy_active, full_duplex_active, speed_10_active, link_up_active}, 4'h1)
    force_mode = 8'h27;
    tick(2);
    `CHK({outside_phy_active, full_duplex_active, speed_10_active, link_up_active}, 4'hf)
    force_mode = 8'h20;
    tick(2);
    `CHK({outside_phy_active, full_duplex_active, speed_10_active, link_up_active}, 4'h8)
    force_mode = 8'h00;
    test_strap_one = 1'b0;
    wr(NET_STATUS_ADDR, 8'h00);
    wr(NET_CONTROL_ADDR, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      wr(NET_CONTROL_ADDR, {2'h0, 3'h6, i[1:0], 1'b0});
      tick(2);
      `CHK({loopback_select, forced_collision_test, write_one_clear_select}, {i[1:0], i != 0, 1'b1})
    end
    $display("test phy and loopback done");
  endtask : t_phy
  logic [15:0] len_tab[4] = '{16'h0220, 16'h021f, 16'h0800, 16'h0801};
  logic [7:0] sts_tab[4] = '{8'h41, 8'h43, 8'h43, 8'h41};
  task automatic t_wake_rx();
    wr(NET_CONTROL_ADDR, 8'h40);
    wake_pulse();
    rc(NET_STATUS_ADDR, 8'h60);
    wr(NET_STATUS_ADDR, 8'h20);
    rc(NET_STATUS_ADDR, 8'h40);
    wake_pulse();
    wr(NET_CONTROL_ADDR, 8'h00);
    rc(NET_STATUS_ADDR, 8'h40);
    wake_pulse();
    rc(NET_STATUS_ADDR, 8'h40);
    wr(OVF_COUNTER_ADDR, 8'h00);
    `CHK(ovf_counter_clear, 1'b1)
    rc(OVF_COUNTER_ADDR, 8'h00);
    `CHK(ovf_counter_clear, 1'b1)
    rx_frame_pending = 1'b1;
    foreach (len_tab[i])
    begin
      rx_fifo_free_bytes = len_tab[i];
      tick(2);
      rc(NET_STATUS_ADDR, sts_tab[i]);
    end
    $display("test wake and receive done");
  endtask : t_wake_rx
  task automatic t_swrst();
    wr(TX_CONTROL_ADDR, 8'h66);
    wr(NET_CONTROL_ADDR, 8'h61);
    tick(3);
    `CHK(soft_reset_active, 1'b1)
    `CHK({wake_function_enable, write_one_clear_select}, 2'h2)
    rc(NET_CONTROL_ADDR, 8'h41);
    rc(TX_CONTROL_ADDR, 8'h00);
    tick(1000);
    `CHK(soft_reset_active, 1'b0)
    rc(NET_CONTROL_ADDR, 8'h40);
    wr(NET_CONTROL_ADDR, 8'h01);
    wr(NET_CONTROL_ADDR, 8'h00);
    tick(2);
    `CHK(soft_reset_active, 1'b0)
    $display("test software reset done");
  endtask : t_swrst
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #60us;
    n_fail++;
    $display("ERROR %0t: watchdog expired", $time);
    end_of_test();
  end
  initial
  begin
    {srst, ce, reg_wr, reg_rd, test_strap_one, wake_event, rx_frame_pending} = 7'h60;
    {reg_addr, reg_wdata, force_mode, tx_byte_count, tx_collision_count} = '0;
    rx_fifo_free_bytes = 16'hffff;
    link_req = 1'b1;
    duplex_req = 1'b0;
    tick(16);
    srst = 1'b0;
    t_reset();
    t_tx();
    t_phy();
    t_wake_rx();
    t_swrst();
    end_of_test();
  end
endmodule : tb_top
